// ### src/sfp_params.svh
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// command codes
`define SFP_CMD_WRITE_ENABLE_CMD_CODE 8'h06
`define SFP_CMD_WRITE_DISABLE_CMD_CODE 8'h04
`define SFP_CMD_RDSR_CODE 8'h05
`define SFP_CMD_STATUS_WRITE_CMD_CODE 8'h01
`define SFP_CMD_PAGE_CODE 8'h02
`define SFP_CMD_SECT_CODE 8'h20
`define SFP_CMD_BLK1_CODE 8'hd8
`define SFP_CMD_BLK2_CODE 8'h52
`define SFP_CMD_CHIP1_CODE 8'hc7
`define SFP_CMD_CHIP2_CODE 8'h60
`define SFP_CMD_SLEEP_CODE 8'hb9
`define SFP_CMD_WAKE_CODE 8'hab
`define SFP_CMD_OTP_CODE 8'h3a

// status byte field positions
`define SFP_ST_WIP 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LO 2
`define SFP_ST_BP_HI 4
`define SFP_ST_LOCK 7
`define SFP_STATUS_RESET 8'h00

// page and array
`define SFP_PAGE_BYTES 256
`define SFP_ADDR_BITS 24
`define SFP_PROT_HALF 24'h040000
`define SFP_PROT_QUARTER 24'h060000
`define SFP_PROT_EIGHTH 24'h070000

// cycle times, in microseconds, and the clock rate
`define SFP_CLK_MHZ 50
`define SFP_T_STATUS_US 10
`define SFP_T_PAGE_US 1500
`define SFP_T_SECT_US 150000
`define SFP_T_BLOCK_US 800000
`define SFP_T_CHIP_US 5000000
`define SFP_CYC(us) ((us) * `SFP_CLK_MHZ)

`endif

// ### src/sfp_pkg.sv
package sfp_pkg;

  typedef enum logic [2:0] {
    SFP_OP_NONE   = 3'b000,
    SFP_OP_STATUS = 3'b001,
    SFP_OP_PAGE   = 3'b010,
    SFP_OP_SECT   = 3'b011,
    SFP_OP_BLOCK  = 3'b100,
    SFP_OP_CHIP   = 3'b101
  } sfp_op_type;

  typedef enum logic [1:0] {
    SFP_PW_STANDBY = 2'b00,
    SFP_PW_ACTIVE  = 2'b01,
    SFP_PW_SLEEP   = 2'b10
  } sfp_power_type;

endpackage

// ### src/sfp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for one pin
module sfp_sync (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pin
  input wire logic pin_i,
  input wire logic reset_val_i,
  output logic sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sfp_sync_state_type;

  sfp_sync_state_type state, next_state;

  always_comb begin
    next_state = state;
    next_state.meta = pin_i;
    next_state.sync = state.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign sync_o = state.sync ^ reset_val_i;

endmodule

// ### src/sfp_page_buf.sv
`timescale 1ns/1ps
`include "sfp_params.svh"
// page latch for one program operation; registered read port
module sfp_page_buf (
  // clock
  input wire logic clk_i,
  input wire logic ce_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem [0:`SFP_PAGE_BYTES-1];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// ### src/sfp_ctrl.sv
`timescale 1ns/1ps
`include "sfp_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - works with bus clock modes 0 and 3
// - sample input on rise, drive on fall
// - page program at most 256 bytes, wraps
// - write enable then page program sequence
// - erases fill sector, block or array
// - busy bit set during every internal cycle
// - standby only after internal cycle ends
// - deep sleep ignores all but wake; status read still answered
// - modifying commands need write enable latch
// - latch cleared at reset and completions
// - write commands need whole byte count
// - protect bits choose read-only region
// - hardware mode freezes lock and protect
// - otp lock guards otp sector once
// - otp status write only sets lock
// - hold pauses link, internal cycle continues
// - hold starts with clock low
// - hold ends with clock low
// - hold floats output, ignores clock, input
// - deselect in hold resets interface
// - write enable command sets latch
// - write disable clears latch and otp mode
// - busy device ignores array accesses
// - all bytes travel msb first
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int unsigned T_STATUS_CYC = `SFP_CYC(`SFP_T_STATUS_US),
  parameter int unsigned T_PAGE_CYC = `SFP_CYC(`SFP_T_PAGE_US),
  parameter int unsigned T_SECT_CYC = `SFP_CYC(`SFP_T_SECT_US),
  parameter int unsigned T_BLOCK_CYC = `SFP_CYC(`SFP_T_BLOCK_US),
  parameter int unsigned T_CHIP_CYC = `SFP_CYC(`SFP_T_CHIP_US)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  // array port
  output logic arr_start_o,
  output sfp_op_type arr_op_o,
  output logic [23:0] arr_addr_o,
  output logic arr_otp_o,
  output logic [7:0] arr_len_o,
  input wire logic [7:0] arr_rd_addr_i,
  output logic [7:0] arr_data_o,
  // status
  output logic [7:0] status_o,
  output sfp_power_type power_o,
  output logic otp_mode_o
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sclk_s, cs_n_s, sdi_s, hold_n_s, wp_n_s;

  sfp_sync u_sync_sclk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(sclk_i), .reset_val_i(1'b0), .sync_o(sclk_s));
  // inverted pins rest at 1 during reset
  sfp_sync u_sync_cs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(~cs_n_i), .reset_val_i(1'b1), .sync_o(cs_n_s));
  sfp_sync u_sync_sdi (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(sdi_i), .reset_val_i(1'b0), .sync_o(sdi_s));
  sfp_sync u_sync_hold (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(~hold_n_i), .reset_val_i(1'b1), .sync_o(hold_n_s));
  sfp_sync u_sync_wp (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pin_i(~wp_n_i), .reset_val_i(1'b1), .sync_o(wp_n_s));

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic sclk_q;
    logic hold_q;
    logic in_hold;
    logic hold_dead;
    logic [7:0] shift;
    logic [12:0] bits;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [8:0] data_cnt;
    logic [7:0] pg_ptr;
    logic [7:0] out_sh;
    logic out_en;
    logic sdo;
    logic write_in_progress_flag;
    logic write_enable_latch;
    logic [2:0] bp;
    logic lock;
    logic otp_lock;
    logic otp_mode;
    logic sleep;
    logic [7:0] wr_stat;
    sfp_op_type op;
    // wide enough for a full-array wipe at the system clock rate
    logic [27:0] timer;
    logic start;
    logic [23:0] op_addr;
    logic [7:0] op_len;
    logic op_otp;
  } sfp_state_type;

  sfp_state_type s, n;

  // region locked by protect bits
  function automatic logic region_locked(input logic [2:0] bp,
                                         input logic [23:0] a);
    logic r;
    r = 1'b0;
    unique case (bp)
      3'b000: r = 1'b0;
      3'b001: r = (a >= `SFP_PROT_EIGHTH);
      3'b010: r = (a >= `SFP_PROT_QUARTER);
      3'b011: r = (a >= `SFP_PROT_HALF);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic [27:0] cyc(input int unsigned c);
    return 28'(c);
  endfunction

  logic sclk_rise, sclk_fall, sel, hw_mode, pg_wr;
  logic [7:0] byte_in;

  assign sel = ~cs_n_s;
  assign sclk_rise = sclk_s & ~s.sclk_q;
  assign sclk_fall = ~sclk_s & s.sclk_q;
  assign hw_mode = s.lock & ~wp_n_s;
  assign byte_in = {s.shift[6:0], sdi_s};
  assign pg_wr = sel & ~s.in_hold & sclk_rise & (s.bits[2:0] == 3'd7)
    & (s.cmd == `SFP_CMD_PAGE_CODE) & (s.bits >= 13'd31)
    & ~s.write_in_progress_flag & ~s.sleep;

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic byte_done, whole, ok_addr, ok_sel;
    n = s;
    n.start = 1'b0;
    n.sclk_q = sclk_s;
    n.hold_q = hold_n_s;
    byte_done = 1'b0;
    whole = (s.bits[2:0] == 3'd0) && (s.bits != 13'd0);
    ok_addr = 1'b0;
    ok_sel = 1'b0;

    // internal cycle keeps running regardless of hold or select
    if (s.write_in_progress_flag) begin
      if (s.timer != 28'd0) begin
        n.timer = s.timer - 28'd1;
      end else begin
        n.write_in_progress_flag = 1'b0;
        n.write_enable_latch = 1'b0;
        if (s.op == SFP_OP_STATUS) begin
          if (s.otp_mode) begin
            n.otp_lock = 1'b1;
          end else if (!hw_mode) begin
            n.bp = s.wr_stat[`SFP_ST_BP_HI:`SFP_ST_BP_LO];
            n.lock = s.wr_stat[`SFP_ST_LOCK];
          end
        end else begin
          n.start = 1'b1;
        end
      end
    end

    if (!sel) begin
      // hold state and shifter cleared on deselect
      if (s.sclk_q == 1'b0 || s.hold_dead == 1'b0) begin
        n.in_hold = 1'b0;
      end
      n.hold_dead = s.in_hold;
      n.out_en = 1'b0;
      n.bits = '0;
      n.data_cnt = '0;
      if (s.bits != 13'd0 && !s.in_hold && whole) begin
        ok_sel = 1'b1;
      end
      if (s.hold_dead) begin
        n.hold_dead = ~hold_n_s;
      end
    end else if (s.hold_dead) begin
      n.hold_dead = ~hold_n_s;
      n.out_en = 1'b0;
    end else begin
      // hold enters and leaves only with clock low
      if (!sclk_s) begin
        n.in_hold = ~hold_n_s;
      end
      // enable kept through hold; sdo_oe_o masks it so output resumes
      if (!s.in_hold) begin
        if (sclk_rise) begin
          n.shift = byte_in;
          n.bits = s.bits + 13'd1;
          if (s.bits[2:0] == 3'd7) begin
            byte_done = 1'b1;
          end
        end
        if (sclk_fall) begin
          n.sdo = s.out_sh[7];
          n.out_sh = {s.out_sh[6:0], s.out_sh[7]};
          n.out_en = (s.cmd == `SFP_CMD_RDSR_CODE) && (s.bits >= 13'd8);
        end
      end
    end

    if (byte_done) begin
      if (s.bits[12:3] == 10'd0) begin
        n.cmd = byte_in;
        if (byte_in == `SFP_CMD_RDSR_CODE) begin
          n.out_sh = status_o;
        end
      end else if (s.bits[12:3] <= 10'd3) begin
        n.addr = {s.addr[15:0], byte_in};
        if (s.cmd == `SFP_CMD_STATUS_WRITE_CMD_CODE && s.bits[12:3] == 10'd1) begin
          n.wr_stat = byte_in;
        end
      end else if (s.cmd == `SFP_CMD_PAGE_CODE) begin
        // bytes past the page end wrap inside it
        n.pg_ptr = s.pg_ptr + 8'd1;
        if (s.data_cnt != 9'(`SFP_PAGE_BYTES)) begin
          n.data_cnt = s.data_cnt + 9'd1;
        end
      end
      if (s.bits[12:3] == 10'd3) begin
        n.pg_ptr = byte_in;
      end
      if (s.cmd == `SFP_CMD_RDSR_CODE) begin
        n.out_sh = status_o;
      end
    end

    // command executes on deselect at a byte boundary
    if (ok_sel) begin
      ok_addr = s.otp_mode ? ~s.otp_lock : ~region_locked(s.bp, s.addr);
      if (s.sleep) begin
        if (s.cmd == `SFP_CMD_WAKE_CODE) begin
          n.sleep = 1'b0;
        end
      end else if (!s.write_in_progress_flag) begin
        unique case (s.cmd)
          `SFP_CMD_WRITE_ENABLE_CMD_CODE: n.write_enable_latch = 1'b1;
          `SFP_CMD_WRITE_DISABLE_CMD_CODE: begin
            n.write_enable_latch = 1'b0;
            n.otp_mode = 1'b0;
          end
          `SFP_CMD_OTP_CODE: n.otp_mode = 1'b1;
          `SFP_CMD_SLEEP_CODE: n.sleep = 1'b1;
          `SFP_CMD_STATUS_WRITE_CMD_CODE: begin
            if (s.write_enable_latch && s.bits == 13'd16 && !(hw_mode && !s.otp_mode)) begin
              n.write_in_progress_flag = 1'b1;
              n.op = SFP_OP_STATUS;
              n.timer = cyc(T_STATUS_CYC);
            end
          end
          `SFP_CMD_PAGE_CODE: begin
            if (s.write_enable_latch && s.bits >= 13'd40 && ok_addr) begin
              n.write_in_progress_flag = 1'b1;
              n.op = SFP_OP_PAGE;
              n.timer = cyc(T_PAGE_CYC);
              n.op_addr = {s.addr[23:8], 8'h00};
              n.op_len = 8'(s.data_cnt - 9'd1);
            end
          end
          `SFP_CMD_SECT_CODE: begin
            if (s.write_enable_latch && s.bits == 13'd32 && ok_addr) begin
              n.write_in_progress_flag = 1'b1;
              n.op = SFP_OP_SECT;
              n.timer = cyc(T_SECT_CYC);
              n.op_addr = {s.addr[23:12], 12'h000};
            end
          end
          `SFP_CMD_BLK1_CODE, `SFP_CMD_BLK2_CODE: begin
            if (s.write_enable_latch && s.bits == 13'd32 && ok_addr) begin
              n.write_in_progress_flag = 1'b1;
              n.op = SFP_OP_BLOCK;
              n.timer = cyc(T_BLOCK_CYC);
              n.op_addr = {s.addr[23:16], 16'h0000};
            end
          end
          `SFP_CMD_CHIP1_CODE, `SFP_CMD_CHIP2_CODE: begin
            if (s.write_enable_latch && s.bits == 13'd8 && s.bp == 3'b000) begin
              n.write_in_progress_flag = 1'b1;
              n.op = SFP_OP_CHIP;
              n.timer = cyc(T_CHIP_CYC);
              n.op_addr = '0;
            end
          end
          default: n.cmd = s.cmd;
        endcase
      end
      n.op_otp = s.otp_mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  sfp_page_buf u_page (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .wr_en_i(pg_wr),
    .wr_addr_i(s.pg_ptr),
    .wr_data_i(byte_in),
    .rd_addr_i(arr_rd_addr_i),
    .rd_data_o(arr_data_o)
  );

  always_comb begin
    status_o = `SFP_STATUS_RESET;
    status_o[`SFP_ST_WIP] = s.write_in_progress_flag;
    status_o[`SFP_ST_WEL] = s.write_enable_latch;
    status_o[`SFP_ST_BP_HI:`SFP_ST_BP_LO] = s.bp;
    status_o[`SFP_ST_LOCK] = s.otp_mode ? s.otp_lock : s.lock;
  end

  // standby waits for internal cycle to finish
  always_comb begin
    if (s.sleep) begin
      power_o = SFP_PW_SLEEP;
    end else if (sel || s.write_in_progress_flag) begin
      power_o = SFP_PW_ACTIVE;
    end else begin
      power_o = SFP_PW_STANDBY;
    end
  end

  assign sdo_o = s.sdo;
  assign sdo_oe_o = s.out_en & sel & ~s.in_hold;
  assign arr_start_o = s.start;
  assign arr_op_o = s.op;
  assign arr_addr_o = s.op_addr;
  assign arr_otp_o = s.op_otp;
  assign arr_len_o = s.op_len;
  assign otp_mode_o = s.otp_mode;

endmodule

// ### dv/sfp_ctrl_properties.sv
`timescale 1ns/1ps
module sfp_ctrl_props
  import sfp_pkg::*;
(
  // clock and pins
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  // outputs
  input wire logic sdo_oe_o,
  input wire logic arr_start_o,
  input wire sfp_op_type arr_op_o,
  input wire logic [7:0] status_o,
  input wire sfp_power_type power_o,
  input wire logic otp_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  property p_busy_active;
    status_o[0] [*2] |-> power_o == SFP_PW_ACTIVE;
  endproperty
  a_busy_active: assert property (p_busy_active)
    else $error("busy but not active");
  // six cycles cover pin sync plus command decode
  property p_idle_standby;
    (cs_n_i && !status_o[0]) [*6] |-> power_o != SFP_PW_ACTIVE;
  endproperty
  a_idle_standby: assert property (p_idle_standby)
    else $error("active while idle");
  property p_done_clears;
    arr_start_o |-> ##1 status_o[1:0] == 2'b00;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("busy or latch left after commit");
  property p_start_after_busy;
    arr_start_o |-> $past(status_o[0]) && arr_op_o != SFP_OP_NONE;
  endproperty
  a_start_after_busy: assert property (p_start_after_busy)
    else $error("commit without busy cycle");
  property p_busy_needs_latch;
    $rose(status_o[0]) |-> $past(status_o[1]);
  endproperty
  a_busy_needs_latch: assert property (p_busy_needs_latch)
    else $error("cycle started without latch");
  property p_busy_min;
    $rose(status_o[0]) |-> status_o[0] [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_hold_float;
    (!cs_n_i && !hold_n_i && !sclk_i) [*6] |-> !sdo_oe_o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven in hold");
  property p_sleep_quiet;
    power_o == SFP_PW_SLEEP |-> !status_o[0] && !arr_start_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("cycle during deep sleep");
  property p_hw_lock;
    status_o[7] && !wp_n_i && !otp_mode_o |=>
      otp_mode_o || $stable(status_o[7:2]);
  endproperty
  a_hw_lock: assert property (p_hw_lock)
    else $error("locked status changed");
endmodule

bind sfp_ctrl sfp_ctrl_props sfp_ctrl_props_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .sclk_i(sclk_i),
  .cs_n_i(cs_n_i),
  .hold_n_i(hold_n_i),
  .wp_n_i(wp_n_i),
  .sdo_oe_o(sdo_oe_o),
  .arr_start_o(arr_start_o),
  .arr_op_o(arr_op_o),
  .status_o(status_o),
  .power_o(power_o),
  .otp_mode_o(otp_mode_o)
);

// ### dv/sfp_spi_master.sv
`timescale 1ns/1ps
module sfp_spi_master (
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic hold_n_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  logic mode3 = 1'b0;
  logic [7:0] rx = 8'h00;
  logic oe_held = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    hold_n_o = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // sends the top n bits of d; hold_at picks a bit to pause before
  task automatic frame(input logic [39:0] d, input int n, input int hold_at);
    // clock settles at its idle level before select falls
    sclk_o = mode3;
    #80;
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      if (i == hold_at) begin
        #40;
        hold_n_o = 1'b0;
        #160;
        oe_held = sdo_oe_i;
        sdi_o = ~d[39 - i];
        sclk_o = 1'b1; // stray pulse the device must ignore
        #80;
        sclk_o = 1'b0;
        #80;
        hold_n_o = 1'b1;
        #80;
      end
      sdi_o = d[39 - i];
      #80;
      sclk_o = 1'b1;
      // a floating output reads back inverted
      rx = {rx[6:0], sdo_oe_i ? sdo_i : ~sdo_i};
      #80;
    end
    sclk_o = mode3;
    #80;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #320;
  endtask
  // four bits of d, then deselect while paused, then hold released
  task automatic cut_in_hold(input logic [7:0] d);
    sclk_o = mode3;
    #80;
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < 4; i++) begin
      sclk_o = 1'b0;
      sdi_o = d[7 - i];
      #80;
      sclk_o = 1'b1;
      #80;
    end
    sclk_o = 1'b0;
    hold_n_o = 1'b0;
    #160;
    cs_n_o = 1'b1;
    #160;
    hold_n_o = 1'b1;
    #160;
    sclk_o = mode3;
    #160;
  endtask
endmodule

// ### dv/tb_sfp_ctrl.sv
`timescale 1ns/1ps
module tb_sfp_ctrl import sfp_pkg::*; ();
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wp_n_i = 1'b1;
  logic sclk, cs_n, sdi, hold_n, sdo_o, sdo_oe_o, arr_start_o, arr_otp_o;
  logic otp_mode_o;
  logic [7:0] arr_rd_addr_i = 8'h00, arr_len_o, arr_data_o, status_o;
  logic [23:0] arr_addr_o;
  sfp_op_type arr_op_o;
  sfp_power_type power_o;
  int n_mismatch = 0, samples_checked = 0, seed = 27, cyc = 0, starts = 0;

  sfp_spi_master sfp_spi_master_inst (.sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi), .hold_n_o(hold_n), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));
  sfp_ctrl #(.T_STATUS_CYC(20), .T_PAGE_CYC(50), .T_SECT_CYC(80),
    .T_BLOCK_CYC(100), .T_CHIP_CYC(600)) sfp_ctrl_inst (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
    .arr_start_o(arr_start_o), .arr_op_o(arr_op_o), .arr_addr_o(arr_addr_o),
    .arr_otp_o(arr_otp_o), .arr_len_o(arr_len_o), .arr_data_o(arr_data_o),
    .arr_rd_addr_i(arr_rd_addr_i), .status_o(status_o), .power_o(power_o),
    .otp_mode_o(otp_mode_o));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (arr_start_o === 1'b1) starts++;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [39:0] d, input int n);
    @(posedge clk_i);
    #2;
    sfp_spi_master_inst.frame(d, n, -1);
    repeat (6) @(posedge clk_i);
    #2;
  endtask
  task automatic settle();
    for (int i = 0; i < 1000 && status_o[0] !== 1'b0; i++) @(posedge clk_i);
    #2;
  endtask
  task automatic op(input logic [39:0] d, input int n, input int exp_n);
    int s0;
    s0 = starts;
    send({8'h06, 32'h0}, 8);
    send(d, n);
    settle();
    chk(24'(starts - s0), 24'(exp_n));
  endtask
  task automatic wstat(input logic [7:0] v);
    op({8'h01, v, 24'h0}, 16, 0);
  endtask
  function automatic logic prot(input logic [2:0] bp, input logic [23:0] a);
    case (bp)
      3'h0: return 1'b0;
      3'h1: return a >= 24'h070000;
      3'h2: return a >= 24'h060000;
      3'h3: return a >= 24'h040000;
      default: return 1'b1;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] a;
    logic [7:0] code;
    logic ok;
    repeat (5) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    chk(status_o, 8'h00);
    send({8'h06, 32'h0}, 8);
    chk(status_o[1], 1'b1);
    sfp_spi_master_inst.frame({8'h05, 32'h0}, 16, 11);
    chk(sfp_spi_master_inst.rx, 8'h02);
    chk(sfp_spi_master_inst.oe_held, 1'b0);
    op({8'h01, 8'h1c, 24'h0}, 15, 0);
    chk(status_o, 8'h02);
    send({8'h04, 32'h0}, 8);
    chk(status_o[1], 1'b0);
    send({8'h01, 8'h1c, 24'h0}, 16);
    chk(status_o, 8'h00);
    sfp_spi_master_inst.cut_in_hold(8'h06);
    chk(status_o, 8'h00);
    send({8'h06, 32'h0}, 8);
    chk(status_o[1], 1'b1);
    // each protect level, one random and one boundary address
    for (int k = 0; k < 16; k++) begin
      sfp_spi_master_inst.mode3 = 1'($random(seed));
      if (k[0] == 1'b0) wstat({3'h0, k[3:1], 2'h0});
      chk(status_o, {3'h0, k[3:1], k[0] & !ok, 1'b0});
      a = k[0] ? 24'h070000 : {5'h00, 19'($random(seed))};
      code = $random(seed) & 1 ? 8'h20 : ($random(seed) & 1 ? 8'hd8 : 8'h52);
      ok = !prot(k[3:1], a);
      op({code, a, 8'h0}, 32, int'(ok));
      if (ok) begin
        chk(24'(arr_op_o), code == 8'h20 ? 24'(SFP_OP_SECT) :
          24'(SFP_OP_BLOCK));
        chk(arr_addr_o, code == 8'h20 ? {a[23:12], 12'h0} :
          {a[23:16], 16'h0});
        chk(status_o[1], 1'b0);
      end
    end
    op({8'hc7, 32'h0}, 8, 0);
    wstat(8'h00);
    op({8'hc7, 32'h0}, 8, 1);
    op({8'h60, 32'h0}, 8, 1);
    chk(24'(arr_op_o), 24'(SFP_OP_CHIP));
    // enable and sector wipe sent while a chip wipe still runs
    a = 24'(starts);
    send({8'h06, 32'h0}, 8);
    send({8'hc7, 32'h0}, 8);
    send({8'h06, 32'h0}, 8);
    send({8'h20, 32'h0}, 32);
    settle();
    chk(24'(starts) - a, 24'd1);
    chk(24'(arr_op_o), 24'(SFP_OP_CHIP));
    chk(status_o[1], 1'b0);
    code = 8'($random(seed));
    op({8'h02, 24'h012345, code}, 40, 1);
    chk(24'(arr_op_o), 24'(SFP_OP_PAGE));
    chk(arr_len_o, 8'h00);
    arr_rd_addr_i = 8'h45;
    repeat (2) @(posedge clk_i);
    #2;
    chk(arr_data_o, code);
    send({8'hb9, 32'h0}, 8);
    chk(power_o, SFP_PW_SLEEP);
    send({8'h06, 32'h0}, 8);
    chk(status_o[1], 1'b0);
    send({8'hab, 32'h0}, 32);
    chk(power_o, SFP_PW_STANDBY);
    wstat(8'h84);
    wp_n_i = 1'b0;
    wstat(8'h00);
    chk(status_o[7:2], 6'h21);
    wp_n_i = 1'b1;
    wstat(8'h00);
    chk(status_o[7:2], 6'h00);
    send({8'h3a, 32'h0}, 8);
    chk(otp_mode_o, 1'b1);
    op({8'h20, 32'h0}, 32, 1);
    chk(arr_otp_o, 1'b1);
    wstat(8'h1c);
    chk(status_o[7:2], 6'h20);
    op({8'h20, 32'h0}, 32, 0);
    send({8'h04, 32'h0}, 8);
    chk(otp_mode_o, 1'b0);
    summarize();
  end
endmodule
